// [bench/abx_chk_asserts.sv]
// Purpose: Port checks for the execute block
// Assumes: Enable bit stays set while ops run
// Notes: Bound to every execute block instance
`timescale 1ns/1ps
`default_nettype none
module abx_chk
(
  input wire logic clk,
  input wire logic reset,
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic [7:0] op_imm,
  input wire logic [2:0] op_bit,
  input wire logic op_dest,
  input wire logic op_ready,
  input wire logic skip_next,
  input wire logic [7:0] file_rdata,
  input wire logic file_we,
  input wire logic [7:0] file_wdata,
  input wire logic [7:0] acc_out,
  input wire logic carry_flag,
  input wire logic half_carry_flag,
  input wire logic zero_flag
);
  logic tk;
  logic tbit;
  logic [7:0] opnd;
  logic [8:0] sum;
  logic [2:0] aflg;
  logic [7:0] andv;
  logic [7:0] bitv;
  logic [2:0] flg;
  assign tk = op_valid && op_ready;
  assign tbit = file_rdata[op_bit];
  assign opnd = op_code[0] ? op_imm : file_rdata;
  assign sum = {1'b0, acc_out} + {1'b0, opnd};
  assign aflg = {sum[8], ({1'b0, acc_out[3:0]} + {1'b0, opnd[3:0]} > 5'h0F), sum[7:0] == 8'h00};
  assign andv = acc_out & opnd;
  assign bitv = op_code[0] ? file_rdata & ~(8'h01 << op_bit) : file_rdata | (8'h01 << op_bit);
  assign flg = {carry_flag, half_carry_flag, zero_flag};
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  chk_add_acc: assert property (tk && op_code inside {4'h1, 4'h2} && !op_dest
    |=> acc_out == 8'($past(sum))) else $error("add to acc wrong");
  chk_add_flags: assert property (tk && op_code inside {4'h1, 4'h2}
    |=> flg == $past(aflg)) else $error("add flags wrong");
  chk_file_dest: assert property (tk && op_dest && op_code inside {4'h2, 4'h4}
    |=> file_we && $stable(acc_out)
    && file_wdata == ($past(op_code) == 4'h2 ? 8'($past(sum)) : $past(andv)))
    else $error("file dest wrong");
  chk_and_acc: assert property (tk && op_code inside {4'h3, 4'h4} && !op_dest
    |=> acc_out == $past(andv)) else $error("and to acc wrong");
  chk_and_flags: assert property (tk && op_code inside {4'h3, 4'h4}
    |=> zero_flag == ($past(andv) == 8'h00) && $stable(carry_flag) && $stable(half_carry_flag))
    else $error("and flags wrong");
  chk_bit_write: assert property (tk && op_code inside {4'h5, 4'h6}
    |=> file_we && file_wdata == $past(bitv) && $stable(flg)) else $error("bit op wrong");
  chk_skip_taken: assert property (tk && op_code inside {4'h7, 4'h8} && tbit == op_code[3]
    |=> skip_next && !op_ready ##1 !skip_next && op_ready) else $error("skip slot wrong");
  chk_skip_none: assert property (tk && op_code inside {4'h7, 4'h8} && tbit != op_code[3]
    |=> !skip_next && !file_we && $stable(flg)) else $error("false skip");
  chk_one_cycle: assert property (tk && op_code inside {[4'h1:4'h6]}
    |=> op_ready && !skip_next) else $error("op not single cycle");
  cover property (tk && op_code == 4'h8 ##1 skip_next);
  cover property (tk && op_code == 4'h2 && op_dest ##1 file_we);
  cover property (tk && op_code == 4'h1 ##1 carry_flag && half_carry_flag);
endmodule
bind abx_exec abx_chk i_chk (.clk, .reset, .op_valid, .op_code, .op_imm, .op_bit, .op_dest,
  .op_ready, .skip_next, .file_rdata, .file_we, .file_wdata, .acc_out, .carry_flag,
  .half_carry_flag, .zero_flag);
`default_nettype wire

// [bench/abx_fmem.sv]
// Purpose: File register memory facing the execute block
// Assumes: Write arrives one cycle after the op cycle
// Notes: Op address is latched so the late write lands in the right place
`timescale 1ns/1ps
`default_nettype none
module abx_fmem
(
  input wire logic clk,
  input wire logic [6:0] file_addr,
  output logic [7:0] file_rdata,
  input wire logic file_we,
  input wire logic [7:0] file_wdata
);
  logic [7:0] mem [128];
  logic [6:0] addr_q;
  assign file_rdata = mem[file_addr];
  always @(posedge clk)
  begin
    addr_q <= file_addr;
    if (file_we)
      mem[addr_q] <= file_wdata;
  end
endmodule
`default_nettype wire

// [bench/tb.sv]
// Purpose: Self-checking bench for the execute block
// Assumes: Rows run in order, each row starting from the previous state
// Notes: Skips, APB access and a second reset follow the row loop
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module tb;
  typedef struct packed {
    logic [3:0] code;
    logic [7:0] imm;
    logic [6:0] addr;
    logic [2:0] bsel;
    logic dest;
    logic [7:0] acc;
    logic [2:0] flg;
    logic [7:0] mem;
  } abx_row_t;
  abx_row_t rows [12] = '{
    '{4'h1, 8'hFF, 7'h05, 3'h0, 1'b0, 8'hFF, 3'h0, 8'hF0},
    '{4'h1, 8'h01, 7'h05, 3'h0, 1'b0, 8'h00, 3'h7, 8'hF0},
    '{4'h1, 8'h0F, 7'h05, 3'h0, 1'b0, 8'h0F, 3'h0, 8'hF0},
    '{4'h2, 8'h00, 7'h7F, 3'h0, 1'b0, 8'h1E, 3'h2, 8'h0F},
    '{4'h2, 8'h00, 7'h05, 3'h0, 1'b1, 8'h1E, 3'h4, 8'h0E},
    '{4'h3, 8'h00, 7'h05, 3'h0, 1'b0, 8'h00, 3'h5, 8'h0E},
    '{4'h1, 8'h3C, 7'h05, 3'h0, 1'b0, 8'h3C, 3'h0, 8'h0E},
    '{4'h4, 8'h00, 7'h05, 3'h0, 1'b1, 8'h3C, 3'h0, 8'h0C},
    '{4'h4, 8'h00, 7'h00, 3'h0, 1'b1, 8'h3C, 3'h1, 8'h00},
    '{4'h6, 8'h00, 7'h00, 3'h7, 1'b0, 8'h3C, 3'h1, 8'h80},
    '{4'h5, 8'h00, 7'h7F, 3'h0, 1'b0, 8'h3C, 3'h1, 8'h0E},
    '{4'h4, 8'h00, 7'h7F, 3'h0, 1'b0, 8'h0C, 3'h0, 8'h0E}};
  // Code, address, bit, skip expected
  logic [14:0] sk [4] = '{{4'h7, 7'h7F, 3'h0, 1'b1}, {4'h8, 7'h7F, 3'h0, 1'b0},
    {4'h8, 7'h00, 3'h7, 1'b1}, {4'h7, 7'h00, 3'h7, 1'b0}};
  logic clk, reset, op_valid, op_dest, op_ready, skip_next, file_we;
  logic carry_flag, half_carry_flag, zero_flag, psel, penable, pwrite, pready, pslverr;
  logic [3:0] op_code;
  logic [7:0] op_imm, file_rdata, file_wdata, acc_out, paddr;
  logic [6:0] op_file_addr, file_addr;
  logic [2:0] op_bit, flg;
  logic [31:0] pwdata, prdata, rd;
  int err_count = 0;
  int check_count = 0;
  assign flg = {carry_flag, half_carry_flag, zero_flag};
  abx_exec i_dut (.clk, .reset, .op_valid, .op_code, .op_imm, .op_file_addr, .op_bit, .op_dest,
    .op_ready, .skip_next, .file_addr, .file_rdata, .file_we, .file_wdata, .acc_out, .carry_flag,
    .half_carry_flag, .zero_flag, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);
  abx_fmem i_mem (.clk, .file_addr, .file_rdata, .file_we, .file_wdata);
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic do_op(input logic [3:0] c, input logic [7:0] i, input logic [6:0] a,
    input logic [2:0] b, input logic d);
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_imm <= i;
    op_file_addr <= a;
    op_bit <= b;
    op_dest <= d;
    @(posedge clk);
    op_valid <= 1'b0;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    err_count++;
    close_out;
  end
  initial
  begin
    {reset, op_valid, op_code, op_imm, op_file_addr, op_bit, op_dest} = {1'b1, 24'h000000};
    {psel, penable, pwrite, paddr, pwdata} = 43'h0;
    i_mem.mem[0] = 8'h81;
    i_mem.mem[5] = 8'hF0;
    i_mem.mem[127] = 8'h0F;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    foreach (rows[n])
    begin
      do_op(rows[n].code, rows[n].imm, rows[n].addr, rows[n].bsel, rows[n].dest);
      @(posedge clk);
      #1;
      `CHK("acc", rows[n].acc, acc_out)
      `CHK("flags", rows[n].flg, flg)
      `CHK("file", rows[n].mem, i_mem.mem[rows[n].addr])
    end
    foreach (sk[n])
    begin
      do_op(sk[n][14:11], 8'h00, sk[n][10:4], sk[n][3:1], 1'b0);
      #1;
      `CHK("skip", sk[n][0], skip_next)
      `CHK("ready", ~sk[n][0], op_ready)
      @(posedge clk);
    end
    `CHK("acc kept", 8'h0C, acc_out)
    apb(1'b1, abx_pkg::OFF_ACC, 32'h000000A5);
    apb(1'b0, abx_pkg::OFF_ACC, 32'h00000000);
    `CHK("apb acc", 32'h000000A5, rd)
    do_op(4'h1, 8'h5B, 7'h00, 3'h0, 1'b0);
    @(posedge clk);
    #1;
    `CHK("acc", 8'h00, acc_out)
    `CHK("flags", 3'h7, flg)
    apb(1'b0, 8'h40, 32'h00000000);
    `CHK("unmapped", 32'h00000000, rd)
    apb(1'b0, abx_pkg::OFF_STATUS, 32'h00000000);
    `CHK("status", 32'h00000007, rd)
    // Seventeen ops taken so far
    apb(1'b0, abx_pkg::OFF_COUNT, 32'h00000000);
    `CHK("count", 32'h00000011, rd)
    apb(1'b1, abx_pkg::OFF_CONTROL, 32'h00000003);
    apb(1'b0, abx_pkg::OFF_COUNT, 32'h00000000);
    `CHK("count clr", 32'h00000000, rd)
    `CHK("pslverr", 1'b0, pslverr)
    // Disabled core refuses ops
    apb(1'b1, abx_pkg::OFF_ACC, 32'h0000005A);
    apb(1'b1, abx_pkg::OFF_CONTROL, 32'h00000000);
    do_op(4'h1, 8'h01, 7'h00, 3'h0, 1'b0);
    @(posedge clk);
    #1;
    `CHK("refused acc", 8'h5A, acc_out)
    `CHK("refused ready", 1'b0, op_ready)
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1;
    `CHK("reset flags", 3'h0, flg)
    `CHK("reset acc", 8'h00, acc_out)
    `CHK("reset ready", 1'b1, op_ready)
    `CHK("reset skip", 1'b0, skip_next)
    do_op(4'h1, 8'h81, 7'h00, 3'h0, 1'b0);
    #1;
    `CHK("post reset op", 8'h81, acc_out)
    close_out;
  end
endmodule
`default_nettype wire

// [inc/abx_alu_if.sv]
// Purpose: Carrier between the execute sequencer and its arithmetic unit
// Assumes: Single clock, purely combinational unit
// Notes: None
`timescale 1ns/1ps
`default_nettype none
interface abx_alu_if;
  abx_pkg::abx_op_t op;
  logic [abx_pkg::DATA_W-1:0] acc;
  logic [abx_pkg::DATA_W-1:0] opnd;
  logic [abx_pkg::BIT_W-1:0] bit_sel;
  logic [abx_pkg::DATA_W-1:0] result;
  logic carry;
  logic half_carry;
  logic zero;
  logic bit_val;
  modport seq (output op, output acc, output opnd, output bit_sel,
               input result, input carry, input half_carry, input zero, input bit_val);
  modport alu (input op, input acc, input opnd, input bit_sel,
               output result, output carry, output half_carry, output zero, output bit_val);
endinterface
`default_nettype wire

// [inc/abx_pkg.sv]
// Purpose: Shared constants and types for the add/AND/bit-op execute block
// Assumes: 8-bit data, 7-bit file addresses, APB register access
// Notes: Offsets are byte addresses of 32-bit words
package abx_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int BIT_W = 3;
  localparam int FILE_DEPTH = 128;
  // APB register offsets
  localparam logic [7:0] OFF_ACC = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_CONTROL = 8'h08;
  localparam logic [7:0] OFF_COUNT = 8'h0C;
  // Status field positions
  localparam int POS_CARRY = 0;
  localparam int POS_HALF = 1;
  localparam int POS_ZERO = 2;
  localparam int POS_SKIP = 3;
  // Control field positions
  localparam int POS_ENABLE = 0;
  localparam int POS_CLR_CNT = 1;
  // Reset values and unmapped read value
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [2:0] RST_FLAGS = 3'h0;
  localparam logic [1:0] RST_CONTROL = 2'h1;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [31:0] UNMAPPED_VAL = 32'h00000000;

  typedef enum logic [3:0] {
    ABX_OP_NONE = 4'h0,
    ABX_OP_ADD_IMM = 4'h1,
    ABX_OP_ADD_FILE = 4'h2,
    ABX_OP_AND_IMM = 4'h3,
    ABX_OP_AND_FILE = 4'h4,
    ABX_OP_BIT_CLR = 4'h5,
    ABX_OP_BIT_SET = 4'h6,
    ABX_OP_TEST_ZERO = 4'h7,
    ABX_OP_TEST_ONE = 4'h8
  } abx_op_t;

  typedef enum logic [0:0] {
    ABX_ST_RUN = 1'b0,
    ABX_ST_NOP = 1'b1
  } abx_state_t;
endpackage

// [logic/abx_alu.sv]
// Purpose: Combinational add, AND and bit manipulation for the execute block
// Assumes: Operands valid in the same cycle
// Notes: Zero is computed for every op, carry and half carry for adds only; the sequencer decides which to keep
`timescale 1ns/1ps
`default_nettype none
module abx_alu
(
  abx_alu_if.alu alu
);
  function automatic logic [4:0] abx_nib_add(input logic [3:0] a, input logic [3:0] b,
                                             input logic ci);
    abx_nib_add = {1'b0, a} + {1'b0, b} + {4'h0, ci};
  endfunction

  logic [4:0] lo_sum;
  logic [4:0] hi_sum;
  logic [7:0] mask;

  always_comb
  begin
    lo_sum = abx_nib_add(alu.acc[3:0], alu.opnd[3:0], 1'b0);
    hi_sum = abx_nib_add(alu.acc[7:4], alu.opnd[7:4], lo_sum[4]);
    mask = 8'h01 << alu.bit_sel;
    alu.bit_val = |(alu.opnd & mask);
    alu.carry = 1'b0;
    alu.half_carry = 1'b0;
    unique case (alu.op)
      abx_pkg::ABX_OP_ADD_IMM, abx_pkg::ABX_OP_ADD_FILE:
      begin
        alu.result = {hi_sum[3:0], lo_sum[3:0]};
        alu.carry = hi_sum[4];
        alu.half_carry = lo_sum[4];
      end
      abx_pkg::ABX_OP_AND_IMM, abx_pkg::ABX_OP_AND_FILE:
        alu.result = alu.acc & alu.opnd;
      abx_pkg::ABX_OP_BIT_CLR:
        alu.result = alu.opnd & ~mask;
      abx_pkg::ABX_OP_BIT_SET:
        alu.result = alu.opnd | mask;
      default:
        alu.result = alu.opnd;
    endcase
    alu.zero = (alu.result == 8'h00);
  end
endmodule
`default_nettype wire

// [logic/abx_exec.sv]
// Purpose: Execute stage for add, AND, bit set/clear and bit-test-skip ops
// Assumes: Decoder presents one op per cycle with a valid strobe; file
//          register read data is combinational from file_addr
// Notes: Accumulator and flags also visible and writable over APB
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module abx_exec
(
  input wire logic clk,
  input wire logic reset,
  // Decoded instruction
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic [7:0] op_imm,
  input wire logic [6:0] op_file_addr,
  input wire logic [2:0] op_bit,
  input wire logic op_dest,
  output logic op_ready,
  output logic skip_next,
  // File register memory
  output logic [6:0] file_addr,
  input wire logic [7:0] file_rdata,
  output logic file_we,
  output logic [7:0] file_wdata,
  // Results
  output logic [7:0] acc_out,
  output logic carry_flag,
  output logic half_carry_flag,
  output logic zero_flag,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  abx_alu_if alu_bus ();

  abx_alu u_alu
  (
    .alu(alu_bus)
  );

  abx_pkg::abx_state_t state_q, state_d;
  abx_pkg::abx_op_t op;
  logic [7:0] acc_q, acc_d;
  logic carry_q, carry_d;
  logic half_q, half_d;
  logic zero_q, zero_d;
  logic [1:0] ctrl_q, ctrl_d;
  logic [15:0] count_q, count_d;
  logic [31:0] prdata_q, prdata_d;
  logic [7:0] wdata_q, wdata_d;
  logic we_q, we_d;
  logic skip_q, skip_d;
  logic apb_wr, apb_rd;
  logic run, take;

  function automatic logic abx_is_file_op(input abx_pkg::abx_op_t o);
    abx_is_file_op = (o == abx_pkg::ABX_OP_ADD_FILE) || (o == abx_pkg::ABX_OP_AND_FILE);
  endfunction

  function automatic logic abx_hit(input logic [7:0] a, input logic [7:0] off);
    abx_hit = (a == off);
  endfunction

  assign op = abx_pkg::abx_op_t'(op_code);
  assign run = ctrl_q[abx_pkg::POS_ENABLE];
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;
  // Decoder may present next op whenever the enable bit is set and no no-op slot is in progress
  assign op_ready = run && (state_q == abx_pkg::ABX_ST_RUN);
  assign take = op_valid && op_ready;
  assign file_addr = op_file_addr;
  assign file_we = we_q;
  assign file_wdata = wdata_q;
  assign acc_out = acc_q;
  assign carry_flag = carry_q;
  assign half_carry_flag = half_q;
  assign zero_flag = zero_q;
  assign skip_next = skip_q;
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  assign alu_bus.op = op;
  assign alu_bus.acc = acc_q;
  assign alu_bus.opnd = (op == abx_pkg::ABX_OP_ADD_IMM || op == abx_pkg::ABX_OP_AND_IMM)
                        ? op_imm : file_rdata;
  assign alu_bus.bit_sel = op_bit;

  always_comb
  begin
    state_d = state_q;
    acc_d = acc_q;
    carry_d = carry_q;
    half_d = half_q;
    zero_d = zero_q;
    ctrl_d = ctrl_q;
    count_d = count_q;
    we_d = 1'b0;
    wdata_d = wdata_q;
    skip_d = 1'b0;
    // No-op slot replaces the discarded following instruction
    if (state_q == abx_pkg::ABX_ST_NOP)
    begin
      state_d = abx_pkg::ABX_ST_RUN;
    end
    else if (take)
    begin
      count_d = count_q + 16'h0001;
      unique case (op)
        abx_pkg::ABX_OP_ADD_IMM, abx_pkg::ABX_OP_ADD_FILE:
        begin
          carry_d = alu_bus.carry;
          half_d = alu_bus.half_carry;
          zero_d = alu_bus.zero;
        end
        abx_pkg::ABX_OP_AND_IMM, abx_pkg::ABX_OP_AND_FILE:
          zero_d = alu_bus.zero;
        abx_pkg::ABX_OP_TEST_ZERO:
          if (!alu_bus.bit_val)
          begin
            state_d = abx_pkg::ABX_ST_NOP;
            skip_d = 1'b1;
          end
        abx_pkg::ABX_OP_TEST_ONE:
          if (alu_bus.bit_val)
          begin
            state_d = abx_pkg::ABX_ST_NOP;
            skip_d = 1'b1;
          end
        default:
        begin
        end
      endcase
      if (op == abx_pkg::ABX_OP_ADD_IMM || op == abx_pkg::ABX_OP_AND_IMM)
        acc_d = alu_bus.result;
      else if (abx_is_file_op(op) && !op_dest)
        acc_d = alu_bus.result;
      if ((abx_is_file_op(op) && op_dest) || op == abx_pkg::ABX_OP_BIT_CLR
          || op == abx_pkg::ABX_OP_BIT_SET)
      begin
        we_d = 1'b1;
        wdata_d = alu_bus.result;
      end
    end
    // Software writes; an executing op in the same cycle wins
    if (apb_wr)
    begin
      if (abx_hit(paddr, abx_pkg::OFF_ACC) && !take)
        acc_d = pwdata[7:0];
      if (abx_hit(paddr, abx_pkg::OFF_STATUS) && !take)
      begin
        carry_d = pwdata[abx_pkg::POS_CARRY];
        half_d = pwdata[abx_pkg::POS_HALF];
        zero_d = pwdata[abx_pkg::POS_ZERO];
      end
      if (abx_hit(paddr, abx_pkg::OFF_CONTROL))
        ctrl_d = {1'b0, pwdata[abx_pkg::POS_ENABLE]};
      if (abx_hit(paddr, abx_pkg::OFF_CONTROL) && pwdata[abx_pkg::POS_CLR_CNT] && !take)
        count_d = abx_pkg::RST_COUNT;
    end
  end

  always_comb
  begin
    prdata_d = prdata_q;
    if (apb_rd)
    begin
      if (abx_hit(paddr, abx_pkg::OFF_ACC))
        prdata_d = {24'h000000, acc_q};
      else if (abx_hit(paddr, abx_pkg::OFF_STATUS))
        prdata_d = {28'h0000000, state_q == abx_pkg::ABX_ST_NOP, zero_q, half_q, carry_q};
      else if (abx_hit(paddr, abx_pkg::OFF_CONTROL))
        prdata_d = {30'h0, ctrl_q};
      else if (abx_hit(paddr, abx_pkg::OFF_COUNT))
        prdata_d = {16'h0000, count_q};
      else
        prdata_d = abx_pkg::UNMAPPED_VAL;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= abx_pkg::ABX_ST_RUN;
      acc_q <= abx_pkg::RST_ACC;
      {zero_q, half_q, carry_q} <= abx_pkg::RST_FLAGS;
      ctrl_q <= abx_pkg::RST_CONTROL;
      count_q <= abx_pkg::RST_COUNT;
      we_q <= 1'b0;
      wdata_q <= 8'h00;
      skip_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      state_q <= state_d;
      acc_q <= acc_d;
      carry_q <= carry_d;
      half_q <= half_d;
      zero_q <= zero_d;
      ctrl_q <= ctrl_d;
      count_q <= count_d;
      we_q <= we_d;
      wdata_q <= wdata_d;
      skip_q <= skip_d;
      prdata_q <= prdata_d;
    end
  end
endmodule
`default_nettype wire
